// *** shared/rtc_timer_map.svh ***
// Address map and constants for the timer/alarm indirect access block.
// Assumes a single core clock domain and byte-wide indirect access.
// Notes on behaviour
// - Pointer advances after every snapshot/match byte access, except when a pointer load comes in the same cycle
// - Timer wraps on overflow, keeps counting
// - Match compares full 32-bit wrapping values
// - Perpetual mode never clears timer on match
// - Auto-reset mode clears timer on match
// - Auto-reset mode keeps match value across alarms
`ifndef RTC_TIMER_MAP_SVH
`define RTC_TIMER_MAP_SVH
`define SNAP_BASE 8'h00
`define MATCH_BASE 8'h08
`define LAST_BYTE 8'h0B
`define TIMER_RST 32'h0000_0000
`define MATCH_RST 32'h0000_0000
`define PTR_RST 8'h00
`endif

// *** shared/rtc_timer_pkg.sv ***
// Types for the timer/alarm block.
// Assumes the map header supplies the numbers.
`default_nettype none
package rtc_timer_pkg;
   typedef enum logic [1:0]
   {
      MODE_PERPETUAL = 2'h1,
      MODE_AUTORESET = 2'h2
   } alarm_mode_t;
endpackage : rtc_timer_pkg
`default_nettype wire

// *** src/rtc_byte_regs.sv ***
// Eight byte registers: four snapshot bytes, four match value bytes.
// Assumes the parent decodes the pointer; read data is registered.
`default_nettype none
`include "rtc_timer_map.svh"
module rtc_byte_regs
   import rtc_timer_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic snap_load,
   input wire logic [31:0] snap_value,
   input wire logic wr_en,
   input wire logic [2:0] addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic [31:0] match_value
);
   logic [31:0] snap_reg, snap_next;
   logic [31:0] match_reg, match_next;
   logic [7:0] rd_reg, rd_next;

   always_comb
   begin
      snap_next = snap_load ? snap_value : snap_reg;
      match_next = match_reg;
      // Match value only changes on a write, so it survives alarms
      if (wr_en && addr[2])
      begin
         match_next[8*addr[1:0] +: 8] = wr_data;
      end
      rd_next = addr[2] ? match_reg[8*addr[1:0] +: 8]
                        : snap_reg[8*addr[1:0] +: 8];
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         snap_reg <= `TIMER_RST;
         match_reg <= `MATCH_RST;
         rd_reg <= 8'h00;
      end
      else
      begin
         snap_reg <= snap_next;
         match_reg <= match_next;
         rd_reg <= rd_next;
      end
   end

   assign rd_data = rd_reg;
   assign match_value = match_reg;
endmodule : rtc_byte_regs
`default_nettype wire

// *** src/rtc_timer_alarm.sv ***
// Timer, alarm compare and indirect address/data access.
// Assumes the core drives the access strobes on core_clk, one per cycle.
`default_nettype none
`include "rtc_timer_map.svh"
module rtc_timer_alarm
   import rtc_timer_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic tick_en,
   input wire logic capture_req,
   input wire logic auto_reset_mode,
   input wire logic ptr_wr,
   input wire logic [7:0] ptr_wdata,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] data_wdata,
   output logic [7:0] indirect_address_pointer,
   output logic [7:0] indirect_data_port,
   output logic alarm_event,
   output logic [31:0] timer_value
);
   ////////////////////////////////////////////////////////////////////////
   alarm_mode_t mode_reg, mode_next;
   logic [31:0] timer_reg, timer_next;
   logic [7:0] ptr_reg, ptr_next;
   logic alarm_reg, alarm_next;
   logic [31:0] match_value;
   logic match_hit;
   logic in_window;

   function automatic logic [7:0] ptr_step(input logic [7:0] p);
      ptr_step = p + 8'h01;
   endfunction : ptr_step

   assign in_window = (ptr_reg <= `LAST_BYTE);
   // Full-width equality: both sides wrap alike, so modular sums work
   assign match_hit = tick_en && (timer_reg == match_value);

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      mode_next = auto_reset_mode ? MODE_AUTORESET : MODE_PERPETUAL;
      timer_next = timer_reg;
      if (tick_en)
      begin
         timer_next = timer_reg + 32'h0000_0001; // Wraps to zero
      end
      // Clear on match only in auto-reset mode; perpetual keeps going
      if (match_hit && mode_reg == MODE_AUTORESET)
      begin
         timer_next = `TIMER_RST;
      end
      alarm_next = match_hit;
      ptr_next = ptr_reg;
      if (ptr_wr)
      begin
         ptr_next = ptr_wdata;
      end
      else if ((data_wr || data_rd) && in_window)
      begin
         ptr_next = ptr_step(ptr_reg); // Always on, no disable
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_reg <= MODE_PERPETUAL;
         timer_reg <= `TIMER_RST;
         ptr_reg <= `PTR_RST;
         alarm_reg <= 1'b0;
      end
      else
      begin
         mode_reg <= mode_next;
         timer_reg <= timer_next;
         ptr_reg <= ptr_next;
         alarm_reg <= alarm_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Snapshot bytes cover index 0..3, match bytes 8..11
   rtc_byte_regs u_regs
   (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .snap_load(capture_req),
      .snap_value(timer_reg),
      // A pointer load in the same cycle wins over the data write
      .wr_en(data_wr && !ptr_wr && in_window && ptr_reg >= `MATCH_BASE),
      .addr({ptr_reg[3], ptr_reg[1:0]}),
      .wr_data(data_wdata),
      .rd_data(indirect_data_port),
      .match_value(match_value)
   );

   assign indirect_address_pointer = ptr_reg;
   assign alarm_event = alarm_reg;
   assign timer_value = timer_reg;

   ////////////////////////////////////////////////////////////////////////
   // Pointer checks: every data access inside the window moves it by one, unless a pointer load comes in the same cycle
   chk_ptr_advance: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (!ptr_wr && data_wr && in_window)
      |=> ptr_reg == $past(ptr_reg) + 8'h01
   )
   else $error("pointer did not advance");

   chk_ptr_read_step: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (!ptr_wr && data_rd && in_window)
      |=> ptr_reg == $past(ptr_reg) + 8'h01
   )
   else $error("pointer did not advance on read");

   chk_ptr_load: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      ptr_wr
      |=> ptr_reg == $past(ptr_wdata)
   )
   else $error("pointer load not taken");

   // Outside the window the pointer parks instead of running away
   chk_ptr_park: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (!ptr_wr && !in_window)
      |=> $stable(ptr_reg)
   )
   else $error("pointer moved outside window");

   chk_ptr_idle: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (!ptr_wr && !data_wr && !data_rd)
      |=> $stable(ptr_reg)
   )
   else $error("pointer moved without access");

   ////////////////////////////////////////////////////////////////////////
   // Timer checks, plus the alarm flag on a match
   chk_timer_wrap: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (tick_en && !match_hit && timer_reg == 32'hFFFF_FFFF)
      |=> timer_reg == 32'h0000_0000
   )
   else $error("timer did not wrap");

   chk_timer_step: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (tick_en && !match_hit)
      |=> timer_reg == $past(timer_reg) + 32'h0000_0001
   )
   else $error("timer did not step");

   chk_timer_hold: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !tick_en
      |=> $stable(timer_reg)
   )
   else $error("timer moved without tick");

   chk_match_flag: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (tick_en && timer_reg == match_value)
      |=> alarm_event
   )
   else $error("alarm missed on match");

   chk_perpetual_run: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (match_hit && mode_reg == MODE_PERPETUAL)
      |=> timer_reg == $past(timer_reg) + 32'h0000_0001
   )
   else $error("perpetual timer disturbed");

   chk_auto_clear: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (match_hit && mode_reg == MODE_AUTORESET)
      |=> timer_reg == `TIMER_RST
   )
   else $error("auto-reset timer not cleared");

   ////////////////////////////////////////////////////////////////////////
   // Match value, alarm flag and mode checks
   chk_match_hold: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (alarm_event && !$past(data_wr))
      |-> $stable(match_value)
   )
   else $error("match value changed at alarm");

   // Snapshot bytes are read-only: a write there must not leak across
   chk_snap_ro: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (data_wr && ptr_reg < `MATCH_BASE)
      |=> $stable(match_value)
   )
   else $error("snapshot write changed match value");

   chk_no_false: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !$past(match_hit)
      |-> !alarm_event
   )
   else $error("alarm without match");

   chk_alarm_once: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (alarm_event && !match_hit)
      |=> !alarm_event
   )
   else $error("alarm stretched past one cycle");

   chk_mode_follow: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      auto_reset_mode
      |=> mode_reg == MODE_AUTORESET
   )
   else $error("mode bit not taken");

   chk_mode_perp: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !auto_reset_mode
      |=> mode_reg == MODE_PERPETUAL
   )
   else $error("perpetual mode not taken");
endmodule : rtc_timer_alarm
`default_nettype wire

// *** test/core_model.sv ***
// Core-side model driving the indirect access strobes.
// Assumes one access per core_clk edge, driven by NBA.
`default_nettype none
module core_model
(
   input wire logic core_clk,
   output logic ptr_wr = 1'b0,
   output logic [7:0] ptr_wdata = 8'h00,
   output logic data_wr = 1'b0,
   output logic data_rd = 1'b0,
   output logic [7:0] data_wdata = 8'h00,
   output logic capture_req = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Kind 0 pointer, 1 write, 2 read, 3 capture, else idle
   task acc(input int k, input logic [7:0] v);
      @(posedge core_clk);
      ptr_wr <= k == 0;
      data_wr <= k == 1;
      data_rd <= k == 2;
      capture_req <= k == 3;
      ptr_wdata <= v;
      // Released data toggles so a stale byte never looks valid
      data_wdata <= k == 1 ? v : ~data_wdata;
   endtask : acc
   task arm(input logic [31:0] m);
      acc(0, 8'h08);
      for (int i = 0; i < 4; i++)
         acc(1, m[8 * i +: 8]);
      acc(4, 8'h00);
   endtask : arm
endmodule : core_model
`default_nettype wire

// *** test/rtc_timer_alarm_tb.sv ***
// Self-checking bench with a cycle reference model.
// Assumes core_model drives the access strobes.
`default_nettype none
module rtc_timer_alarm_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic tick_en = 1'b0;
   logic auto_reset_mode = 1'b0;
   logic ptr_wr, data_wr, data_rd, capture_req, alarm_event, a, r;
   logic [7:0] ptr_wdata, data_wdata, indirect_address_pointer;
   logic [7:0] indirect_data_port, d, p;
   logic [31:0] timer_value, t, m, s;
   int mismatches = 0;
   int checked = 0;
   int n;
   int hits = 0;
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) tick_en <= 1'($urandom);
   core_model core (.core_clk(core_clk), .ptr_wr(ptr_wr),
      .ptr_wdata(ptr_wdata), .data_wr(data_wr), .data_rd(data_rd),
      .data_wdata(data_wdata), .capture_req(capture_req));
   rtc_timer_alarm DUT (.core_clk(core_clk), .rst_b(rst_b),
      .tick_en(tick_en), .capture_req(capture_req),
      .auto_reset_mode(auto_reset_mode), .ptr_wr(ptr_wr),
      .ptr_wdata(ptr_wdata), .data_wr(data_wr), .data_rd(data_rd),
      .data_wdata(data_wdata), .alarm_event(alarm_event),
      .indirect_address_pointer(indirect_address_pointer),
      .indirect_data_port(indirect_data_port), .timer_value(timer_value));
   ////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk or negedge rst_b)
      if (!rst_b)
      begin
         {t, m, s, p, a, r} = 106'h0;
      end
      else
      begin
         // Pointer bit 3 picks match or snapshot, so 12 and up alias
         d = p[3] ? m[8 * p[1:0] +: 8] : s[8 * p[1:0] +: 8];
         a = tick_en && t == m;
         if (capture_req)
            s = t;
         // Mode level is registered, so it acts one edge later
         if (tick_en)
            t = a && r ? 32'h0 : t + 32'h1;
         r = auto_reset_mode;
         if (data_wr && !ptr_wr && p[3] && p < 8'h0C)
            m[8 * p[1:0] +: 8] = data_wdata;
         if (ptr_wr)
            p = ptr_wdata;
         else if ((data_wr || data_rd) && p < 8'h0C)
            p = p + 8'h01;
      end
   always @(negedge core_clk)
      if (rst_b)
      begin
         cmp(timer_value, t);
         cmp(alarm_event, a);
         cmp(indirect_address_pointer, p);
         cmp(indirect_data_port, d);
         if (alarm_event === 1'b1)
            hits++;
      end
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task end_sim;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   initial
   begin
      #500000;
      mismatches++;
      end_sim();
   end
   initial
   begin
      void'($urandom(32'h2c58147b));
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (400)
         core.acc($urandom % 5, 8'($urandom));
      $display("random traffic done");
      // Reset mid-run so the auto-reset timer starts below its match
      rst_b <= 1'b0;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      auto_reset_mode <= 1'b1;
      hits = 0;
      core.arm(32'h0000_0005);
      repeat (60) core.acc(4, 8'h00);
      cmp(hits >= 2, 1);
      $display("auto reset done");
      auto_reset_mode <= 1'b0;
      core.arm(t + 32'h20);
      repeat (6)
      begin
         for (n = 0; n < 200 && alarm_event !== 1'b1; n++)
            @(negedge core_clk);
         cmp(n < 200, 1);
         core.arm(m + 32'h20);
      end
      $display("perpetual done");
      end_sim();
   end
endmodule : rtc_timer_alarm_tb
`default_nettype wire
